// [verilog/psc_defines.vh]
// Purpose: constants for the phy special control and error counter bank
// Assumes: register index is the management register number
// Notes:   counter values are 16 bits wide
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// register offsets
`define PSC_ADDR_SPECIAL_CTRL    5'h11
`define PSC_ADDR_PHY_ADDRESS     5'h12
`define PSC_ADDR_FALSE_CARRIER   5'h13
`define PSC_ADDR_DISCONNECT      5'h14
`define PSC_ADDR_ERROR_FRAME     5'h15
`define PSC_ADDR_SYMBOL_ERROR    5'h16
`define PSC_ADDR_PREMATURE_EOF   5'h17
`define PSC_ADDR_SLOW_EOF_ERROR  5'h18

// special control bit positions
`define PSC_BIT_SCRAMBLER_BYPASS 15
`define PSC_BIT_ENC_BYPASS       14
`define PSC_BIT_FORCE_H_PATTERN  13
`define PSC_BIT_FORCE_34_PATTERN 12
`define PSC_BIT_GOOD_LINK        11
`define PSC_BIT_RESERVED         10
`define PSC_BIT_TX_CRS_DISABLE   9
`define PSC_BIT_DYN_PD_DISABLE   8
`define PSC_BIT_AN_LOOPBACK      7
`define PSC_BIT_MDI_TRISTATE     6
`define PSC_BIT_FILTER_BYPASS    5
`define PSC_BIT_AUTO_POL_DISABLE 4
`define PSC_BIT_SQUELCH_DISABLE  3
`define PSC_BIT_EXT_SQUELCH      2
`define PSC_BIT_LINK_DISABLE     1
`define PSC_BIT_JABBER_DISABLE   0

// reset values
`define PSC_RST_SPECIAL_CTRL     16'h0000
`define PSC_RST_PHY_ADDRESS      16'h0001
`define PSC_RST_COUNTER          16'h0000
`define PSC_RST_PREMATURE_EOF    16'h0001
`define PSC_COUNT_FULL           16'hFFFF

// bad symbols folded into one count
`define PSC_SYMBOL_RUN_LEN       3'h6

`endif

// [verilog/psc_regs.v]
// Purpose: phy special control word, address readback and error counters
// Assumes: events are one-cycle pulses synchronous to clock
// Notes:   counters saturate and clear when read; read data a cycle later
`timescale 1ns/10ps
`include "psc_defines.vh"

module psc_regs #(
    parameter CNT_W = 16
) (
    input  wire              clock,
    input  wire              nrst,
    input  wire [4:0]        reg_addr,
    input  wire [15:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [15:0]       reg_rdata,
    input  wire              false_carrier_evt,
    input  wire              disconnect_evt,
    input  wire              frame_active,
    input  wire              rx_error_evt,
    input  wire              symbol_error_evt,
    input  wire              premature_eof_evt,
    input  wire              slow_eof_error_evt,
    output wire              scrambler_bypass,
    output wire              enc_bypass,
    output wire              force_h_pattern,
    output wire              force_34_pattern,
    output wire              good_link_force,
    output wire              tx_crs_disable,
    output wire              dyn_pd_disable,
    output wire              an_loopback,
    output wire              mdi_tristate,
    output wire              filter_bypass,
    output wire              auto_pol_disable,
    output wire              squelch_disable,
    output wire              ext_squelch_en,
    output wire              link_disable,
    output wire              jabber_disable
);

    localparam NCNT = 6;

    reg  [15:0]           ctrl_ff;
    reg  [CNT_W-1:0]      cnt_ff [0:NCNT-1];
    reg  [CNT_W-1:0]      nxt_cnt [0:NCNT-1];
    reg  [NCNT-1:0]       evt;
    reg  [NCNT-1:0]       clr;
    reg                   frame_err_seen_ff;
    reg  [2:0]            sym_run_ff;
    reg  [2:0]            nxt_sym_run;
    reg                   frame_evt;
    reg                   sym_evt;
    integer               i;

    // counter slot for an address, used by clear and read paths
    function [2:0] cnt_slot;
        input [4:0] a;
        begin
            if (a == `PSC_ADDR_FALSE_CARRIER) begin
                cnt_slot = 3'h0;
            end else if (a == `PSC_ADDR_DISCONNECT) begin
                cnt_slot = 3'h1;
            end else if (a == `PSC_ADDR_ERROR_FRAME) begin
                cnt_slot = 3'h2;
            end else if (a == `PSC_ADDR_SYMBOL_ERROR) begin
                cnt_slot = 3'h3;
            end else if (a == `PSC_ADDR_PREMATURE_EOF) begin
                cnt_slot = 3'h4;
            end else if (a == `PSC_ADDR_SLOW_EOF_ERROR) begin
                cnt_slot = 3'h5;
            end else begin
                cnt_slot = 3'h7;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // special control word

    // control word write, reserved bit stored as written
    always @(posedge clock) begin
        if (!nrst) begin
            ctrl_ff <= `PSC_RST_SPECIAL_CTRL;
        end else if (reg_wr && reg_addr == `PSC_ADDR_SPECIAL_CTRL) begin
            ctrl_ff <= reg_wdata;
        end
    end

    assign scrambler_bypass = ctrl_ff[`PSC_BIT_SCRAMBLER_BYPASS];
    assign enc_bypass       = ctrl_ff[`PSC_BIT_ENC_BYPASS];
    assign force_h_pattern  = ctrl_ff[`PSC_BIT_FORCE_H_PATTERN];
    assign force_34_pattern = ctrl_ff[`PSC_BIT_FORCE_34_PATTERN];
    assign good_link_force  = ctrl_ff[`PSC_BIT_GOOD_LINK];
    assign tx_crs_disable   = ctrl_ff[`PSC_BIT_TX_CRS_DISABLE];
    assign dyn_pd_disable   = ctrl_ff[`PSC_BIT_DYN_PD_DISABLE];
    assign an_loopback      = ctrl_ff[`PSC_BIT_AN_LOOPBACK];
    assign mdi_tristate     = ctrl_ff[`PSC_BIT_MDI_TRISTATE];
    assign filter_bypass    = ctrl_ff[`PSC_BIT_FILTER_BYPASS];
    assign auto_pol_disable = ctrl_ff[`PSC_BIT_AUTO_POL_DISABLE];
    assign squelch_disable  = ctrl_ff[`PSC_BIT_SQUELCH_DISABLE];
    assign ext_squelch_en   = ctrl_ff[`PSC_BIT_EXT_SQUELCH];
    assign link_disable     = ctrl_ff[`PSC_BIT_LINK_DISABLE];
    assign jabber_disable   = ctrl_ff[`PSC_BIT_JABBER_DISABLE];

    ////////////////////////////////////////////////////////////////////////
    // event qualification

    always @* begin
        frame_evt = rx_error_evt && frame_active && !frame_err_seen_ff;
    end

    always @(posedge clock) begin
        if (!nrst) begin
            frame_err_seen_ff <= 1'b0;
        end else if (!frame_active) begin
            frame_err_seen_ff <= 1'b0;
        end else if (rx_error_evt) begin
            frame_err_seen_ff <= 1'b1;
        end
    end

    // six consecutive bad symbols count once
    always @* begin
        nxt_sym_run = sym_run_ff;
        sym_evt     = 1'b0;
        if (symbol_error_evt) begin
            if (sym_run_ff == 3'h0) begin
                sym_evt = 1'b1;
            end
            if (sym_run_ff == `PSC_SYMBOL_RUN_LEN - 3'h1) begin
                nxt_sym_run = 3'h0;
            end else begin
                nxt_sym_run = sym_run_ff + 3'h1;
            end
        end else begin
            nxt_sym_run = 3'h0;
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            sym_run_ff <= 3'h0;
        end else begin
            sym_run_ff <= nxt_sym_run;
        end
    end

    // event vector in slot order
    always @* begin
        evt[0] = false_carrier_evt;
        evt[1] = disconnect_evt;
        evt[2] = frame_evt;
        evt[3] = sym_evt;
        evt[4] = premature_eof_evt;
        evt[5] = slow_eof_error_evt;
    end

    ////////////////////////////////////////////////////////////////////////
    // counters

    always @* begin
        for (i = 0; i < NCNT; i = i + 1) begin
            clr[i] = reg_rd && (cnt_slot(reg_addr) == i[2:0]);
            if (clr[i]) begin
                nxt_cnt[i] = evt[i] ? {{(CNT_W-1){1'b0}}, 1'b1}
                                    : {CNT_W{1'b0}};
            end else if (evt[i] && cnt_ff[i] != {CNT_W{1'b1}}) begin
                nxt_cnt[i] = cnt_ff[i] + {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                nxt_cnt[i] = cnt_ff[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCNT; g = g + 1) begin : g_cnt
            always @(posedge clock) begin
                if (!nrst) begin
                    if (g == 4) begin
                        cnt_ff[g] <= `PSC_RST_PREMATURE_EOF;
                    end else begin
                        cnt_ff[g] <= `PSC_RST_COUNTER;
                    end
                end else begin
                    cnt_ff[g] <= nxt_cnt[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read path, data a cycle after the strobe

    always @(posedge clock) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == `PSC_ADDR_SPECIAL_CTRL) begin
                reg_rdata <= ctrl_ff;
            end else if (reg_addr == `PSC_ADDR_PHY_ADDRESS) begin
                reg_rdata <= `PSC_RST_PHY_ADDRESS;
            end else if (cnt_slot(reg_addr) != 3'h7) begin
                reg_rdata <= cnt_ff[cnt_slot(reg_addr)];
            end else begin
                reg_rdata <= 16'h0000;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // psc_regs

// [tb/psc_regs_props.sv]
// Purpose: concurrent checks on the register port of the control bank
// Assumes: one clock, synchronous active-low reset
// Notes:   attached to every psc_regs instance by bind
`timescale 1ns/10ps
module psc_regs_props (
    input wire        clock,
    input wire        nrst,
    input wire [4:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire        false_carrier_evt,
    input wire        disconnect_evt,
    input wire        scrambler_bypass,
    input wire        tx_crs_disable,
    input wire        jabber_disable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // decoded accesses
    wire cw = reg_wr && reg_addr == 5'h11;
    wire ar = reg_rd && reg_addr == 5'h12;
    wire fr = reg_rd && reg_addr == 5'h13;
    wire dr = reg_rd && reg_addr == 5'h14;
    ////////////////////////////////////////////////////////////////////
    AST_ADDR_RO: assert property (
        $past(ar) |-> reg_rdata == 16'h0001) else $error("bad address");
    AST_SCR_BIT: assert property (
        cw |=> scrambler_bypass == $past(reg_wdata[15])) else $error("b15");
    AST_CRS_BIT: assert property (
        cw |=> tx_crs_disable == $past(reg_wdata[9])) else $error("b9");
    AST_JAB_BIT: assert property (
        cw |=> jabber_disable == $past(reg_wdata[0])) else $error("b0");
    AST_CTL_HOLD: assert property (
        !cw |=> $stable({scrambler_bypass, tx_crs_disable, jabber_disable}))
        else $error("control changed without write");
    AST_FC_CLR: assert property (
        fr && !false_carrier_evt ##1 fr |=> reg_rdata == 16'h0000)
        else $error("false carrier not cleared");
    AST_FC_KEEP: assert property (
        fr && false_carrier_evt ##1 fr |=> reg_rdata == 16'h0001)
        else $error("event lost at clear");
    AST_DC_OLD: assert property (
        dr && !disconnect_evt ##1 dr && disconnect_evt |=> reg_rdata == 0)
        else $error("disconnect read not old value");
endmodule // psc_regs_props

bind psc_regs psc_regs_props u_props (.*);

// [tb/psc_mac_model.sv]
// Purpose: management controller model driving the register port
// Assumes: each task is entered just after a rising edge
// Notes:   strobes last one cycle; accesses may run back to back
`timescale 1ns/10ps
module psc_mac_model (
    input  wire        clock,
    input  wire [15:0] reg_rdata,
    output reg  [4:0]  reg_addr = 5'h00,
    output reg  [15:0] reg_wdata = 16'h0000,
    output reg         reg_wr = 1'b0,
    output reg         reg_rd = 1'b0
);
    task wr(input [4:0] a, input [15:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d & 16'hFBFF;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read data stands in the cycle after the strobe
    task rd(input [4:0] a, output [15:0] d);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule // psc_mac_model

// [tb/psc_regs_tb_top.sv]
// Purpose: self-checking bench for the control word and error counters
// Assumes: events are driven here, register traffic by the model
// Notes:   saturation run needs about 66k cycles
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module psc_regs_tb_top;
    reg         clock = 1'b0;
    reg         nrst = 1'b0;
    reg  [3:0]  ev = 4'h0;    // false carrier, disconnect, premature, slow
    reg         fa = 1'b0;
    reg         rxe = 1'b0;
    reg         sym = 1'b0;
    reg  [15:0] d;
    reg  [15:0] w;
    wire [4:0]  reg_addr;
    wire [15:0] reg_wdata;
    wire        reg_wr;
    wire        reg_rd;
    wire [15:0] reg_rdata;
    wire [14:0] ctl;
    int         miscompares = 0;
    int         n_tests = 0;
    int         cyc = 0;
    int         i;
    logic [4:0] evt_addr [4] = '{5'h18, 5'h17, 5'h14, 5'h13};
    ////////////////////////////////////////////////////////////////////
    always #4 clock = ~clock;
    psc_mac_model u_mac (.clock, .reg_rdata, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd);
    psc_regs #(.CNT_W(16)) i_dut (.clock, .nrst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .false_carrier_evt(ev[3]),
        .disconnect_evt(ev[2]), .premature_eof_evt(ev[1]),
        .slow_eof_error_evt(ev[0]), .frame_active(fa), .rx_error_evt(rxe),
        .symbol_error_evt(sym), .scrambler_bypass(ctl[14]),
        .enc_bypass(ctl[13]), .force_h_pattern(ctl[12]),
        .force_34_pattern(ctl[11]), .good_link_force(ctl[10]),
        .tx_crs_disable(ctl[9]), .dyn_pd_disable(ctl[8]),
        .an_loopback(ctl[7]), .mdi_tristate(ctl[6]),
        .filter_bypass(ctl[5]), .auto_pol_disable(ctl[4]),
        .squelch_disable(ctl[3]), .ext_squelch_en(ctl[2]),
        .link_disable(ctl[1]), .jabber_disable(ctl[0]));
    ////////////////////////////////////////////////////////////////////
    task conclude;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk_rd(input [4:0] a, input [15:0] e);
        u_mac.rd(a, d);
        `CHK(d, e)
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 70000) begin
            miscompares++;
            conclude;
        end
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        for (i = 17; i <= 24; i++)
            chk_rd(i[4:0], (i == 18 || i == 23) ? 16'h1 : 16'h0);
        chk_rd(5'h17, 16'h0000);
        chk_rd(5'h00, 16'h0000);
        for (i = 0; i < 16; i++) begin
            u_mac.wr(5'h11, 16'h0001 << i);
            w = (16'h0001 << i) & 16'hFBFF;
            `CHK(ctl, {w[15:11], w[9:0]})
            chk_rd(5'h11, w);
        end
        u_mac.wr(5'h12, 16'hFFFF);
        chk_rd(5'h12, 16'h0001);
        for (i = 0; i < 4; i++) begin
            repeat (3) begin
                ev[i] <= 1'b1;
                @(posedge clock);
                ev[i] <= 1'b0;
                @(posedge clock);
            end
            chk_rd(evt_addr[i], 16'h0003);
        end
        ev[3] <= 1'b1;
        chk_rd(5'h13, 16'h0000);
        ev[3] <= 1'b0;
        chk_rd(5'h13, 16'h0001);
        chk_rd(5'h13, 16'h0000);
        chk_rd(5'h14, 16'h0000);
        ev[2] <= 1'b1;
        chk_rd(5'h14, 16'h0000);
        ev[2] <= 1'b0;
        chk_rd(5'h14, 16'h0001);
        fa  <= 1'b1;
        sym <= 1'b1;
        for (i = 0; i < 7; i++) begin
            rxe <= (i == 0 || i == 3);
            @(posedge clock);
        end
        sym <= 1'b0;
        rxe <= 1'b0;
        @(posedge clock);
        fa <= 1'b0;
        @(posedge clock);
        chk_rd(5'h16, 16'h0002);
        chk_rd(5'h15, 16'h0001);
        ev[2] <= 1'b1;
        repeat (65540) @(posedge clock);
        ev[2] <= 1'b0;
        @(posedge clock);
        chk_rd(5'h14, 16'hFFFF);
        chk_rd(5'h14, 16'h0000);
        conclude;
    end
endmodule // psc_regs_tb_top
